// ==== apc_defs.svh ====
// register offsets, reset values and timing constants of the power controller
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH

// register byte offsets, one aligned 32-bit word each
`define APC_OFS_CTRL 8'h00
`define APC_OFS_KEYSET 8'h04
`define APC_OFS_SERSET 8'h08
`define APC_OFS_DUTY 8'h0C
`define APC_OFS_PROC 8'h10
`define APC_OFS_SOFT 8'h14
`define APC_OFS_CURLIM 8'h18
`define APC_OFS_MONITOR 8'h1C
`define APC_OFS_STATUS 8'h20
`define APC_OFS_FIRE 8'h24

// reset values
`define APC_CTRL_RST 14'h0000
`define APC_PCT_RST 7'h00
`define APC_DUTY_RST 7'h64
`define APC_PROC_RST 24'h640000
`define APC_SOFT_RST 8'h00
`define APC_CURLIM_RST 12'hFFF

// percent arithmetic: divide by 100 as multiply by 656 then shift by 16
`define APC_PCT_MAX 7'h64
`define APC_RECIP_100 32'h0000_0290
`define APC_RECIP_SHIFT 16

// analog span of a 12-bit converter: 4 mA / 1 V sits at one fifth of full
`define APC_ANA_ZERO 12'h333
`define APC_ANA_FULL 12'hFFF
`define APC_POT_FULL 16'h00FF

// soft-start ramp step time, one percent per step unit
`define APC_CLK_MHZ 250
`define APC_RAMP_STEP_US 1000
`define APC_RAMP_STEP_CYC (`APC_RAMP_STEP_US * `APC_CLK_MHZ)

`endif

// ==== apc_pkg.sv ====
// types shared by the power controller design
package apc_pkg;

    typedef enum logic [1:0] {
        APC_M_PHASE = 2'b00,
        APC_M_CYCLE = 2'b01,
        APC_M_ONOFF = 2'b10
    } apc_method_t;

    typedef enum logic [1:0] {
        APC_A_ANALOG = 2'b00,
        APC_A_SERIAL = 2'b01,
        APC_A_ONOFF = 2'b10
    } apc_auto_t;

    typedef enum logic [1:0] {
        APC_E_NONE = 2'b00,
        APC_E_METHOD = 2'b01,
        APC_E_AUTOMAN = 2'b10
    } apc_evt_t;

    typedef enum logic [2:0] {
        APC_MON_INPUT = 3'b000,
        APC_MON_DUTY = 3'b001,
        APC_MON_OUTPUT = 3'b010,
        APC_MON_PHASE = 3'b011,
        APC_MON_CURRENT = 3'b100
    } apc_mon_item_t;

    typedef enum logic [1:0] {
        APC_FS_IDLE = 2'b00,
        APC_FS_DELAY = 2'b01,
        APC_FS_CONDUCT = 2'b10,
        APC_FS_BLOCK = 2'b11
    } apc_fire_t;

    // control word, bits 13..0 of the control register
    typedef struct packed {
        logic cfgLevel;
        logic [1:0] evtAssign;
        logic manKeys;
        logic [1:0] autoSrc;
        logic manual;
        logic [1:0] curve;
        logic [1:0] method;
        logic [2:0] monSel;
    } apc_ctrl_t;

    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] lower;
        logic [7:0] baseUp;
    } apc_proc_t;

    typedef struct packed {
        logic [2:0] item;
        logic [11:0] value;
    } apc_mon_t;

endpackage

// ==== apc_controller.sv ====
// setpoint selection, output processing and thyristor firing control
`timescale 1ns/1ps
`include "apc_defs.svh"

// How it works
// RULE1: three load methods: phase angle, half-cycle optimum cycle, ON/OFF.
// RULE2: phase and cycle control may be swapped while the load runs.
// RULE3: phase control varies conducting part of each half cycle.
// RULE4: cycle control decides on or off for every single half cycle.
// RULE5: cycle control changes the switch only at a mains zero crossing.
// RULE6: ON/OFF control gates the load by the external binary command.
// RULE7: ON/OFF phase angle comes from the manual setting, keys or pot; code forces manual only for the ON/OFF source, not for method ON/OFF.
// RULE8: phase control offers four selectable output-to-phase curves.
// RULE9: five monitor items: input, duty, output, phase angle, load current.
// RULE10: after restart the monitor shows the input value item.
// RULE11: input monitor shows the main setting in force, auto or manual.
// RULE12: duty value is internal duty times external duty, in percent.
// RULE13: output is input with base-up, limits, soft ramp, current limit.
// RULE14: with no processing active the output equals the input.
// RULE15: phase angle follows the curve; proportional mode equals output.
// RULE16: load current monitor exists only on constant-current variants.
// RULE17: main setting from one of analog, serial, ON/OFF, pot or keys.
// RULE18: analog span maps linearly onto zero to 100 percent.
// RULE19: host writes the serial setting; device adopts it as input.
// RULE20: with ON/OFF source the command only gates; input is manual.
// RULE21: key setting clears to zero on restart.
// RULE22: serially written setting is zero after restart.
// RULE23: the pot maps onto the input value non-linearly.
// RULE24: event input open selects automatic, closed selects manual.
// RULE25: configuration level holds the load off; runs after power-up.
// RULE26: duty product and output saturate within zero to 100 percent.
// RULE27: firing decisions are timed from the synchronised zero crossing.
module apc_controller #(
    parameter int RAMP_STEP_CYC = `APC_RAMP_STEP_CYC,
    parameter int HC_W = 24,
    parameter bit CONST_CURRENT = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [11:0] anaCode,
    input wire logic [7:0] potMainCode,
    input wire logic [7:0] potDutyCode,
    input wire logic [11:0] loadCurrent,
    input wire logic onOffCmdPin,
    input wire logic eventPin,
    input wire logic zeroCrossPin,
    output logic gateOut,
    output apc_pkg::apc_mon_t monitorOut
);
    import apc_pkg::*;

    localparam int RW = $clog2(RAMP_STEP_CYC + 1);

    // a times b over 100, saturated at 100; inputs never exceed 100
    function automatic logic [6:0] pctMul(input logic [6:0] a,
                                          input logic [6:0] b);
        logic [31:0] p;
        p = 32'(a) * 32'(b) * `APC_RECIP_100;
        p = p >> `APC_RECIP_SHIFT;
        if (p > 32'(`APC_PCT_MAX)) begin
            p = 32'(`APC_PCT_MAX);
        end
        return p[6:0];
    endfunction

    // clamp an 8-bit value to 100
    function automatic logic [6:0] sat100(input logic [7:0] x);
        if (x > 8'(`APC_PCT_MAX)) begin
            return `APC_PCT_MAX;
        end
        return x[6:0];
    endfunction

    // linear 8-bit pot code to percent
    function automatic logic [6:0] potPct(input logic [7:0] c);
        logic [15:0] p;
        p = 16'(c) * 16'(`APC_PCT_MAX) / `APC_POT_FULL;
        return p[6:0];
    endfunction

    // output value to phase angle; curve 0 is proportional to phase
    function automatic logic [6:0] curveMap(input logic [1:0] crv,
                                            input logic [6:0] x);
        logic [6:0] sq;
        logic [6:0] inv;
        logic [7:0] sum;
        sq = pctMul(x, x);
        inv = pctMul(7'(`APC_PCT_MAX - x), 7'(`APC_PCT_MAX - x));
        sum = 8'(x) + 8'(sq);
        unique case (crv)
            2'b00: return x;
            2'b01: return 7'(`APC_PCT_MAX - inv);
            2'b10: return sq;
            2'b11: return sum[7:1];
        endcase
    endfunction

    // byte-enable merge for register writes
    function automatic logic [31:0] wrMerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic waitReq_r;
    logic [31:0] rdData_r;
    logic [31:0] rdNxt;
    logic wrEn;
    logic [31:0] wrWord;
    apc_ctrl_t ctrl_r;
    logic [6:0] keySet_r;
    logic [6:0] serSet_r;
    logic [6:0] intDuty_r;
    apc_proc_t proc_r;
    logic [7:0] softUp_r;
    logic [7:0] softDn_r;
    logic [11:0] curLim_r;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic zcPrev_r;
    logic zcPulse;
    logic cmdOn;
    logic evtClosed;
    logic manualSel;
    logic [6:0] anaPct;
    logic [6:0] inNxt;
    logic [6:0] inVal_r;
    logic [6:0] dutyVal_r;
    logic [6:0] outVal_r;
    logic [6:0] phase_r;
    logic [6:0] effPh_r;
    logic [6:0] target;
    logic [6:0] curTrim_r;
    logic [RW-1:0] rampCnt_r;
    logic rampTick_r;
    logic [7:0] upCnt_r;
    logic [7:0] dnCnt_r;
    apc_method_t effMethod;
    apc_method_t method_r;
    apc_fire_t fire_r;
    logic gate_r;
    logic [HC_W-1:0] halfCnt_r;
    logic [HC_W-1:0] halfLen_r;
    logic [HC_W-1:0] fireAt_r;
    logic [HC_W-1:0] fireNxt;
    logic [7:0] acc_r;
    logic [7:0] accSum;
    apc_mon_t mon_r;

    // bus slave: one wait cycle, then the answer at the next edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            waitReq_r <= 1'b1;
            rdData_r <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && waitReq_r) begin
            waitReq_r <= 1'b0;
            rdData_r <= avs_read ? rdNxt : rdData_r;
        end else begin
            waitReq_r <= 1'b1;
        end
    end

    assign avs_waitrequest = waitReq_r;
    assign avs_readdata = rdData_r;
    assign wrEn = avs_write && !waitReq_r;

    // read decode; unmapped offsets read as zero
    always_comb begin
        rdNxt = 32'h0000_0000;
        unique case (avs_address)
            `APC_OFS_CTRL: rdNxt = 32'(ctrl_r);
            `APC_OFS_KEYSET: rdNxt = 32'(keySet_r);
            `APC_OFS_SERSET: rdNxt = 32'(serSet_r);
            `APC_OFS_DUTY: rdNxt = 32'(intDuty_r);
            `APC_OFS_PROC: rdNxt = 32'(proc_r);
            `APC_OFS_SOFT: rdNxt = {16'h0000, softDn_r, softUp_r};
            `APC_OFS_CURLIM: rdNxt = 32'(curLim_r);
            `APC_OFS_MONITOR: rdNxt = 32'(mon_r);
            `APC_OFS_STATUS: rdNxt = {1'b0, phase_r, 1'b0, outVal_r,
                                      1'b0, dutyVal_r, 1'b0, inVal_r};
            `APC_OFS_FIRE: rdNxt = {26'h0, gate_r, fire_r, method_r, 1'b0};
            default: rdNxt = 32'h0000_0000;
        endcase
    end

    // writeable registers; settings clear at restart [RULE21] [RULE22]
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_r <= `APC_CTRL_RST;
            keySet_r <= `APC_PCT_RST;
            serSet_r <= `APC_PCT_RST;
            intDuty_r <= `APC_DUTY_RST;
            proc_r <= `APC_PROC_RST;
            softUp_r <= `APC_SOFT_RST;
            softDn_r <= `APC_SOFT_RST;
            curLim_r <= `APC_CURLIM_RST;
        end else if (wrEn) begin
            unique case (avs_address)
                `APC_OFS_CTRL: ctrl_r <= wrWord[13:0];
                `APC_OFS_KEYSET: keySet_r <= sat100(wrWord[7:0]);
                `APC_OFS_SERSET: serSet_r <= sat100(wrWord[7:0]); // [RULE19]
                `APC_OFS_DUTY: intDuty_r <= sat100(wrWord[7:0]);
                `APC_OFS_PROC: proc_r <= wrWord[23:0];
                `APC_OFS_SOFT: begin
                    softUp_r <= wrWord[7:0];
                    softDn_r <= wrWord[15:8];
                end
                `APC_OFS_CURLIM: curLim_r <= wrWord[11:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        wrWord = wrMerge(rdNxt, avs_writedata, avs_byteenable);
    end

    // two-flop synchronisers for command, event and zero-cross pins
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            zcPrev_r <= 1'b0;
        end else begin
            sync1_r <= {zeroCrossPin, eventPin, onOffCmdPin};
            sync2_r <= sync1_r;
            zcPrev_r <= sync2_r[2];
        end
    end

    assign cmdOn = sync2_r[0];
    assign evtClosed = sync2_r[1];
    assign zcPulse = sync2_r[2] && !zcPrev_r; // [RULE27]

    // linear analog span, below 4 mA reads zero [RULE18]
    always_comb begin
        logic [31:0] d;
        d = 32'h0000_0000;
        if (anaCode > `APC_ANA_ZERO) begin
            d = 32'(anaCode - `APC_ANA_ZERO) * 32'(`APC_PCT_MAX)
                / 32'(`APC_ANA_FULL - `APC_ANA_ZERO);
        end
        anaPct = sat100(d[7:0]);
    end

    // source choice: ON/OFF source always takes the manual value
    always_comb begin
        logic [6:0] manVal;
        logic [6:0] autoVal;
        // pot follows a square law, not a straight line [RULE23]
        manVal = ctrl_r.manKeys ? keySet_r
                 : pctMul(potPct(potMainCode), potPct(potMainCode));
        autoVal = (ctrl_r.autoSrc == APC_A_SERIAL) ? serSet_r : anaPct;
        manualSel = ctrl_r.manual;
        if (ctrl_r.autoSrc == APC_A_ONOFF) begin
            manualSel = 1'b1; // [RULE20] [RULE7]
        end else if (ctrl_r.evtAssign == APC_E_AUTOMAN) begin
            manualSel = evtClosed; // [RULE24]
        end
        inNxt = manualSel ? manVal : autoVal; // [RULE17]
    end

    // base-up, limits and current trim give the ramp target [RULE13]
    always_comb begin
        logic [7:0] based;
        logic [6:0] lo;
        logic [6:0] hi;
        based = 8'(inVal_r) + 8'(sat100(proc_r.baseUp));
        lo = sat100(proc_r.lower);
        hi = sat100(proc_r.upper);
        target = sat100(based); // [RULE26]
        if (target > hi) begin
            target = hi;
        end
        if (target < lo) begin
            target = lo;
        end
        target = (target > curTrim_r) ? 7'(target - curTrim_r) : 7'h00;
    end

    // ramp time base shared by soft start and current limiting
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rampCnt_r <= '0;
            rampTick_r <= 1'b0;
        end else if (rampCnt_r == RW'(RAMP_STEP_CYC - 1)) begin
            rampCnt_r <= '0;
            rampTick_r <= 1'b1;
        end else begin
            rampCnt_r <= rampCnt_r + 1'b1;
            rampTick_r <= 1'b0;
        end
    end

    // current trim climbs while over the limit, decays when below
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            curTrim_r <= 7'h00;
        end else if (!CONST_CURRENT) begin
            curTrim_r <= 7'h00;
        end else if (rampTick_r) begin
            if (loadCurrent > curLim_r && curTrim_r < `APC_PCT_MAX) begin
                curTrim_r <= curTrim_r + 1'b1; // [RULE13]
            end else if (loadCurrent <= curLim_r && curTrim_r != 7'h00) begin
                curTrim_r <= curTrim_r - 1'b1;
            end
        end
    end

    // input, duty, output and phase pipeline
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            inVal_r <= 7'h00;
            dutyVal_r <= `APC_DUTY_RST;
            phase_r <= 7'h00;
            effPh_r <= 7'h00;
        end else begin
            inVal_r <= inNxt; // [RULE11]
            dutyVal_r <= pctMul(intDuty_r, potPct(potDutyCode)); // [RULE12]
            phase_r <= curveMap(ctrl_r.curve, outVal_r); // [RULE8] [RULE15]
            effPh_r <= pctMul(phase_r, dutyVal_r); // [RULE26]
        end
    end

    // soft ramp, one percent per set number of steps; zero is instant
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            outVal_r <= 7'h00;
            upCnt_r <= 8'h00;
            dnCnt_r <= 8'h00;
        end else if (outVal_r < target) begin
            dnCnt_r <= 8'h00;
            if (softUp_r == 8'h00) begin
                outVal_r <= target; // [RULE14]
            end else if (rampTick_r) begin
                if (upCnt_r + 8'h01 >= softUp_r) begin
                    upCnt_r <= 8'h00;
                    outVal_r <= outVal_r + 1'b1; // [RULE13]
                end else begin
                    upCnt_r <= upCnt_r + 8'h01;
                end
            end
        end else if (outVal_r > target) begin
            upCnt_r <= 8'h00;
            if (softDn_r == 8'h00) begin
                outVal_r <= target; // [RULE14]
            end else if (rampTick_r) begin
                if (dnCnt_r + 8'h01 >= softDn_r) begin
                    dnCnt_r <= 8'h00;
                    outVal_r <= outVal_r - 1'b1;
                end else begin
                    dnCnt_r <= dnCnt_r + 8'h01;
                end
            end
        end else begin
            upCnt_r <= 8'h00;
            dnCnt_r <= 8'h00;
        end
    end

    // method picked now, applied at the next zero crossing [RULE2]
    always_comb begin
        if (ctrl_r.autoSrc == APC_A_ONOFF
            || ctrl_r.method == APC_M_ONOFF) begin
            effMethod = APC_M_ONOFF; // [RULE1]
        end else if (ctrl_r.evtAssign == APC_E_METHOD) begin
            effMethod = evtClosed ? APC_M_CYCLE : APC_M_PHASE;
        end else if (ctrl_r.method == APC_M_CYCLE) begin
            effMethod = APC_M_CYCLE;
        end else begin
            effMethod = APC_M_PHASE;
        end
    end

    // half-cycle timer, restarted by each zero crossing [RULE27]
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            halfCnt_r <= '0;
            halfLen_r <= '0;
        end else if (zcPulse) begin
            halfCnt_r <= '0;
            halfLen_r <= halfCnt_r;
        end else if (halfCnt_r != '1) begin
            halfCnt_r <= halfCnt_r + 1'b1;
        end
    end

    // firing delay: the last half length times the non-conducting share
    always_comb begin
        logic [63:0] p;
        p = 64'(halfCnt_r) * 64'(`APC_PCT_MAX - effPh_r)
            * 64'(`APC_RECIP_100);
        p = p >> `APC_RECIP_SHIFT;
        fireNxt = p[HC_W-1:0]; // [RULE3]
        accSum = 8'(acc_r) + 8'(effPh_r);
    end

    // firing state machine; the gate drops at a zero crossing unless cycle control fires that half
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fire_r <= APC_FS_IDLE;
            gate_r <= 1'b0;
            acc_r <= 8'h00;
            method_r <= APC_M_PHASE;
            fireAt_r <= '0;
        end else if (ctrl_r.cfgLevel) begin
            fire_r <= APC_FS_IDLE; // [RULE25]
            gate_r <= 1'b0;
            acc_r <= 8'h00;
        end else if (zcPulse) begin
            method_r <= effMethod;
            fireAt_r <= fireNxt;
            unique case (effMethod)
                APC_M_CYCLE: begin
                    // carry accumulator spreads on halves evenly [RULE4]
                    if (accSum >= 8'(`APC_PCT_MAX)) begin
                        acc_r <= accSum - 8'(`APC_PCT_MAX);
                        gate_r <= 1'b1; // [RULE5]
                        fire_r <= APC_FS_CONDUCT;
                    end else begin
                        acc_r <= accSum;
                        gate_r <= 1'b0; // [RULE5]
                        fire_r <= APC_FS_BLOCK;
                    end
                end
                APC_M_PHASE, APC_M_ONOFF: begin
                    acc_r <= 8'h00;
                    gate_r <= 1'b0;
                    if (effPh_r == 7'h00
                        || (effMethod == APC_M_ONOFF && !cmdOn)) begin
                        fire_r <= APC_FS_BLOCK; // [RULE6]
                    end else begin
                        fire_r <= APC_FS_DELAY;
                    end
                end
                default: begin
                    gate_r <= 1'b0;
                    fire_r <= APC_FS_BLOCK;
                end
            endcase
        end else begin
            unique case (fire_r)
                APC_FS_DELAY: begin
                    if (halfCnt_r >= fireAt_r) begin
                        gate_r <= 1'b1; // [RULE3]
                        fire_r <= APC_FS_CONDUCT;
                    end
                end
                APC_FS_IDLE, APC_FS_CONDUCT, APC_FS_BLOCK: ;
            endcase
        end
    end

    assign gateOut = gate_r;

    // monitor item and value; current only on constant-current builds
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mon_r <= '0; // [RULE10]
        end else begin
            mon_r.item <= ctrl_r.monSel;
            unique case (ctrl_r.monSel)
                APC_MON_INPUT: mon_r.value <= 12'(inVal_r); // [RULE9]
                APC_MON_DUTY: mon_r.value <= 12'(dutyVal_r);
                APC_MON_OUTPUT: mon_r.value <= 12'(outVal_r);
                APC_MON_PHASE: mon_r.value <= 12'(phase_r);
                APC_MON_CURRENT:
                    mon_r.value <= CONST_CURRENT ? loadCurrent
                                                 : 12'h000; // [RULE16]
                default: mon_r.value <= 12'h000;
            endcase
        end
    end

    assign monitorOut = mon_r;

endmodule

// ==== apc_monitor.sv ====
// checker watching the power controller ports
`timescale 1ns/1ps
`include "apc_defs.svh"
module apc_monitor (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic zeroCrossPin,
    input wire logic gateOut,
    input apc_pkg::apc_mon_t monitorOut
);
    import apc_pkg::*;
    logic zcSeen_r;
    logic cfgOn_r;
    // snoop a seen crossing and the hold-off bit, no access to internals
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            zcSeen_r <= 1'b0;
            cfgOn_r <= 1'b0;
        end else begin
            if (zeroCrossPin)
                zcSeen_r <= 1'b1;
            if (avs_write && !avs_waitrequest && avs_address == 8'h00)
                cfgOn_r <= avs_writedata[13];
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered");
    a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("waitrequest dropped while idle");
    a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    a_mon_restart: assert property ($rose(rst_n) |-> monitorOut == '0
        && !gateOut && avs_waitrequest) else $error("bad state after restart");
    a_item_legal: assert property (monitorOut.item <= 3'h4)
        else $error("monitor item out of range");
    a_gate_after_zc: assert property ($rose(gateOut) |-> zcSeen_r)
        else $error("gate fired before any zero crossing");
    a_cfg_off: assert property (cfgOn_r |=> !gateOut)
        else $error("gate on in configuration level");
endmodule
bind apc_controller apc_monitor i_apc_monitor (.core_clk, .rst_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .zeroCrossPin, .gateOut, .monitorOut);

// ==== apc_host_model.sv ====
// mains reference and on/off command source upstream of the controller
`timescale 1ns/1ps
module apc_host_model #(
    parameter int HALF_CYC = 64
) (
    input wire logic core_clk,
    input wire logic cmdOn,
    output logic zeroCrossPin,
    output logic onOffCmdPin
);
    int cnt = 0;
    // grid runs free, so crossings never stop, even in reset
    always @(posedge core_clk) begin
        cnt <= (cnt == HALF_CYC - 1) ? 0 : cnt + 1;
        zeroCrossPin <= (cnt < 4);
        onOffCmdPin <= cmdOn;
    end
endmodule

// ==== test_ac_power_setpoint_controller.sv ====
// self-checking bench for the power controller
`timescale 1ns/1ps
module test_ac_power_setpoint_controller;
    import apc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    logic [11:0] ana = 12'h333;
    logic [7:0] potDuty = 8'hFF;
    logic cmdOn = 1'b0;
    logic evt = 1'b0;
    logic zc;
    logic onOff;
    logic gate;
    logic g1;
    apc_mon_t mon;
    int failures = 0;
    int n_compared = 0;
    always #2 core_clk = ~core_clk;
    apc_host_model i_apc_host_model (.core_clk, .cmdOn,
        .zeroCrossPin(zc), .onOffCmdPin(onOff));
    apc_controller #(.RAMP_STEP_CYC(4)) i_apc_controller (.core_clk,
        .rst_n, .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .anaCode(ana), .potMainCode(8'h00),
        .potDutyCode(potDuty), .loadCurrent(12'h000), .onOffCmdPin(onOff),
        .eventPin(evt), .zeroCrossPin(zc), .gateOut(gate),
        .monitorOut(mon));
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one access; the slave decides when, only the bound cuts a hang
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge core_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        rd <= 1'b0;
        wr <= 1'b0;
        failures += (n >= 50);
        if (n >= 50)
            report_and_stop();
    endtask
    task automatic rchk(input logic [7:0] a, input int sh,
        input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk((rdat >> sh) & m, exp);
    endtask
    // wait for a fresh crossing on the pin, then k more cycles
    task automatic atzc(input int k);
        int n;
        n = 0;
        while (zc !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        while (zc !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        failures += (n >= 400);
        if (n >= 400)
            report_and_stop();
        repeat (k) @(posedge core_clk);
    endtask
    task automatic t_basic;
        logic [6:0] tbl [4] = '{7'h14, 7'h24, 7'h04, 7'h0C};
        chk({17'h0, mon}, 32'h0);
        rchk(8'h0C, 0, 32'h7F, 32'h64);
        rchk(8'h18, 0, 32'hFFF, 32'hFFF);
        rchk(8'h80, 0, 32'hFFFFFFFF, 32'h0);
        ana <= 12'hFFF;
        repeat (8) @(posedge core_clk);
        rchk(8'h20, 0, 32'h7F, 32'h64);
        rchk(8'h20, 16, 32'h7F, 32'h64);
        ana <= 12'h333;
        bus(1'b1, 8'h08, 32'h14);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 8'h00, 32'h100 | (c << 5));
            repeat (8) @(posedge core_clk);
            rchk(8'h20, 24, 32'h7F, {25'h0, tbl[c]});
        end
        rchk(8'h20, 0, 32'h7F, 32'h14);
        bus(1'b1, 8'h08, 32'hC8);
        rchk(8'h08, 0, 32'h7F, 32'h64);
        bus(1'b1, 8'h0C, 32'h32);
        bus(1'b1, 8'h00, 32'h101);
        repeat (8) @(posedge core_clk);
        rchk(8'h20, 8, 32'h7F, 32'h32);
        chk({17'h0, mon}, 32'h1032);
        bus(1'b1, 8'h0C, 32'h64);
        bus(1'b1, 8'h00, 32'h480);
        bus(1'b1, 8'h04, 32'h14);
        repeat (8) @(posedge core_clk);
        rchk(8'h20, 0, 32'h7F, 32'h14);
        evt <= 1'b1;
        bus(1'b1, 8'h00, 32'h1500);
        rchk(8'h20, 0, 32'h7F, 32'h14);
        $display("setpoint tests done");
    endtask
    task automatic t_fire;
        bus(1'b1, 8'h00, 32'h108);
        bus(1'b1, 8'h08, 32'h32);
        atzc(12);
        g1 = gate;
        repeat (44) @(posedge core_clk);
        chk({31'h0, gate}, {31'h0, g1});
        atzc(12);
        chk({31'h0, gate}, {31'h0, !g1});
        bus(1'b1, 8'h00, 32'h100);
        atzc(12);
        atzc(12);
        chk({31'h0, gate}, 32'h0);
        repeat (44) @(posedge core_clk);
        chk({31'h0, gate}, 32'h1);
        bus(1'b1, 8'h00, 32'h600);
        bus(1'b1, 8'h04, 32'h64);
        atzc(32);
        chk({31'h0, gate}, 32'h0);
        cmdOn <= 1'b1;
        atzc(32);
        chk({31'h0, gate}, 32'h1);
        bus(1'b1, 8'h00, 32'h2600);
        repeat (2) @(posedge core_clk);
        chk({31'h0, gate}, 32'h0);
        $display("firing tests done");
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_basic();
        t_fire();
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rchk(8'h08, 0, 32'h7F, 32'h0);
        rchk(8'h04, 0, 32'h7F, 32'h0);
        $display("restart test done");
        report_and_stop();
    end
endmodule
